// File: rtl/emb_regs.svh
// Purpose: Constants for the external memory bus interface.
// Assumes: One core clock, four clocks per machine cycle.
// Notes: Offsets, reset values and timing counts only.
`ifndef EMB_REGS_SVH
`define EMB_REGS_SVH
`define EMB_CLK_PER_MC 3'h4
`define EMB_RESET_MC 2'h2
`define EMB_STRETCH_MIN 3'h0
`define EMB_STRETCH_MAX 3'h7
`define EMB_SRAM_TOP 16'h03FF
`define EMB_SRAM_WORDS 1024
`endif

// File: rtl/emb_pkg.sv
// Purpose: Types for the external memory bus interface.
// Assumes: Constants live in emb_regs.svh.
// Notes: Requests travel as one packed struct.
package emb_pkg;
    typedef enum logic [1:0] {
        EMB_CODE_READ = 2'h0,
        EMB_DATA_READ = 2'h1,
        EMB_DATA_WRITE = 2'h2
    } emb_kind_t;
    typedef struct packed {
        emb_kind_t kind;
        logic [15:0] addr;
        logic [7:0] wdata;
    } emb_req_t;
    typedef enum logic [2:0] {
        EMB_IDLE = 3'b000,
        EMB_ADDR = 3'b001,
        EMB_STRB = 3'b011,
        EMB_WAIT = 3'b111,
        EMB_DONE = 3'b010
    } emb_state_t;
endpackage : emb_pkg

// File: rtl/emb_bus.sv
// Purpose: External program and data bus cycles with optional on-chip SRAM.
// Assumes: Core issues one request at a time and waits for DONE.
// Notes: Port 0 pins split into in, out and output enable.
// Notes on behaviour
// (R1) Reset is taken only after the reset input has stayed high for two machine cycles.
// (R2) A machine cycle is four core clocks and all bus timing counts in machine cycles.
// (R3) Code fetches and table reads assert the program fetch strobe.
// (R4) Each external cycle pulses the address latch strobe first.
// (R5) The low address byte and data byte share one eight-bit port.
// (R6) The upper address byte stands on the high port for the whole cycle.
// (R7) External data writes assert the write strobe on bit 6 of the alternate port.
// (R8) External data reads assert the read strobe on bit 7 of the alternate port.
// (R9) Data moves last from two to nine machine cycles by a stretch setting.
// (R10) The on-chip SRAM covers data addresses 0000H through 03FFH.
// (R11) The SRAM is reached only by data moves and is selected by software.
// (R12) Bit 0 of the four-bit port may serve as a wait input.
// (R13) Data goes to the SRAM only while the SRAM enable is set.
// (R14) The SRAM enable clears at reset so all data goes external.
// (R15) Data addresses above 03FFH always go external.
// (R16) An asserted wait holds the strobe and adds whole machine cycles; the code obeys wait only on data moves, never on code fetches.
// (R17) SRAM accesses make no strobes and finish in the shortest time.
`timescale 1ns/10ps
`include "emb_regs.svh"
module emb_bus
    import emb_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic REQ_VALID,
    input wire emb_req_t REQ,
    input wire logic [2:0] STRETCH,
    input wire logic SRAM_EN_WR,
    input wire logic SRAM_EN_VAL,
    input wire logic WAIT_EN,
    input wire logic P4_0_IN,
    input wire logic [7:0] LOW_ADDR_DATA_PORT_IN,
    output logic [7:0] LOW_ADDR_DATA_PORT_OUT,
    output logic LOW_ADDR_DATA_PORT_OE,
    output logic [7:0] HIGH_ADDR_PORT,
    output logic ADDR_LATCH,
    output logic PROGRAM_FETCH_STROBE_N,
    output logic WRITE_STROBE_N,
    output logic READ_STROBE_N,
    output logic ONCHIP_SRAM_ENABLE,
    output logic INT_RESET,
    output logic DONE,
    output logic [7:0] RDATA
);
    // ************************************************
    // Reset qualification
    // ************************************************
    logic rst_q_reg;
    // Input is sampled so a glitch shorter than two machine cycles is ignored.
    logic [2:0] rsync_reg;
    logic [3:0] hold_reg;
    always_ff @(posedge CORE_CLK) begin
        rsync_reg <= {rsync_reg[1:0], RST};
        if (rsync_reg[2] && rsync_reg[1]) begin
            if (hold_reg != 4'h8) begin
                hold_reg <= hold_reg + 4'h1; // see (R1)
            end
        end else begin
            hold_reg <= 4'h0;
        end
        // Eight high clocks on the pin give only seven agreeing synchroniser edges, hence one below the count.
        rst_q_reg <= (hold_reg >= 4'({`EMB_RESET_MC, 2'h0} - 4'h1)); // see (R1)
    end
    wire logic rst_i = rst_q_reg;

    // ************************************************
    // Wait input synchroniser
    // ************************************************
    logic [2:0] wsync_reg;
    logic wait_reg;
    always_ff @(posedge CORE_CLK) begin
        if (rst_i) begin
            wsync_reg <= 3'h0;
            wait_reg <= 1'b0;
        end else begin
            wsync_reg <= {wsync_reg[1:0], P4_0_IN};
            if (wsync_reg[2] == wsync_reg[1]) begin
                wait_reg <= ~wsync_reg[2] & WAIT_EN; // see (R12)
            end
        end
    end

    // ************************************************
    // SRAM enable and decode
    // ************************************************
    logic sram_en_reg;
    always_ff @(posedge CORE_CLK) begin
        if (rst_i) begin
            sram_en_reg <= 1'b0; // see (R14)
        end else if (SRAM_EN_WR) begin
            sram_en_reg <= SRAM_EN_VAL; // see (R11)
        end
    end
    function automatic logic is_sram(input emb_req_t r, input logic en);
        is_sram = en && (r.kind != EMB_CODE_READ) && (r.addr <= `EMB_SRAM_TOP); // see (R10) (R13) (R15)
    endfunction : is_sram
    logic [7:0] sram_mem [0:`EMB_SRAM_WORDS-1];

    // ************************************************
    // Bus cycle sequencer
    // ************************************************
    emb_state_t state_reg;
    emb_req_t req_reg;
    logic [1:0] phase_reg;
    logic [2:0] mc_left_reg;
    logic mc_end;
    assign mc_end = (phase_reg == 2'(`EMB_CLK_PER_MC - 3'h1)); // see (R2)
    always_ff @(posedge CORE_CLK) begin
        if (rst_i) begin
            state_reg <= EMB_IDLE;
            phase_reg <= 2'h0;
            mc_left_reg <= 3'h0;
            req_reg <= '0;
        end else begin
            phase_reg <= (state_reg == EMB_IDLE) ? 2'h0 : phase_reg + 2'h1;
            unique case (state_reg)
                EMB_IDLE: begin
                    if (REQ_VALID && !is_sram(REQ, sram_en_reg)) begin
                        req_reg <= REQ;
                        state_reg <= EMB_ADDR;
                        mc_left_reg <= (REQ.kind == EMB_CODE_READ) ? 3'h0 : STRETCH; // see (R9)
                    end
                end
                EMB_ADDR: if (mc_end) state_reg <= EMB_STRB; // see (R2)
                EMB_STRB: begin
                    if (mc_end) begin
                        if (mc_left_reg != `EMB_STRETCH_MIN) begin
                            mc_left_reg <= mc_left_reg - 3'h1; // see (R9)
                        end else if (wait_reg && req_reg.kind != EMB_CODE_READ) begin
                            state_reg <= EMB_WAIT; // see (R16)
                        end else begin
                            state_reg <= EMB_DONE;
                        end
                    end
                end
                EMB_WAIT: if (mc_end && !wait_reg) state_reg <= EMB_DONE; // see (R16)
                EMB_DONE: state_reg <= EMB_IDLE;
                default: state_reg <= EMB_IDLE;
            endcase
        end
    end

    // ************************************************
    // Pins, SRAM port and answers
    // ************************************************
    wire logic strb = (state_reg == EMB_STRB) || (state_reg == EMB_WAIT);
    always_ff @(posedge CORE_CLK) begin
        if (rst_i) begin
            LOW_ADDR_DATA_PORT_OUT <= 8'h00;
            LOW_ADDR_DATA_PORT_OE <= 1'b0;
            HIGH_ADDR_PORT <= 8'h00;
            ADDR_LATCH <= 1'b0;
            PROGRAM_FETCH_STROBE_N <= 1'b1;
            WRITE_STROBE_N <= 1'b1;
            READ_STROBE_N <= 1'b1;
            DONE <= 1'b0;
            RDATA <= 8'h00;
        end else begin
            HIGH_ADDR_PORT <= (state_reg == EMB_IDLE) ? 8'h00 : req_reg.addr[15:8]; // see (R6)
            ADDR_LATCH <= (state_reg == EMB_ADDR) && (phase_reg < 2'h2); // see (R4)
            if (state_reg == EMB_ADDR) begin
                LOW_ADDR_DATA_PORT_OUT <= req_reg.addr[7:0]; // see (R5)
                LOW_ADDR_DATA_PORT_OE <= 1'b1;
            end else if (strb && req_reg.kind == EMB_DATA_WRITE) begin
                LOW_ADDR_DATA_PORT_OUT <= req_reg.wdata; // see (R5)
                LOW_ADDR_DATA_PORT_OE <= 1'b1;
            end else begin
                LOW_ADDR_DATA_PORT_OE <= 1'b0;
            end
            PROGRAM_FETCH_STROBE_N <= ~(strb && req_reg.kind == EMB_CODE_READ); // see (R3)
            WRITE_STROBE_N <= ~(strb && req_reg.kind == EMB_DATA_WRITE); // see (R7)
            READ_STROBE_N <= ~(strb && req_reg.kind == EMB_DATA_READ); // see (R8)
            DONE <= 1'b0;
            if (state_reg == EMB_IDLE && REQ_VALID && is_sram(REQ, sram_en_reg)) begin
                DONE <= 1'b1; // see (R17)
                RDATA <= sram_mem[REQ.addr[9:0]];
            end else if (state_reg == EMB_DONE) begin
                DONE <= 1'b1;
                RDATA <= LOW_ADDR_DATA_PORT_IN;
            end
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (state_reg == EMB_IDLE && REQ_VALID && is_sram(REQ, sram_en_reg) && REQ.kind == EMB_DATA_WRITE) begin
            sram_mem[REQ.addr[9:0]] <= REQ.wdata; // see (R11)
        end
    end
    always_ff @(posedge CORE_CLK) begin
        ONCHIP_SRAM_ENABLE <= sram_en_reg;
        INT_RESET <= rst_i;
    end

    // ************************************************
    // Checks
    // ************************************************
    sram_quiet_a: assert property (@(posedge CORE_CLK) disable iff (rst_i) // see (R17)
        (state_reg == EMB_IDLE && REQ_VALID && is_sram(REQ, sram_en_reg)) |=> (DONE && WRITE_STROBE_N && !ADDR_LATCH))
        else $error("SRAM access touched the bus.");
    rd_strobe_a: assert property (@(posedge CORE_CLK) disable iff (rst_i) // see (R8)
        (strb && req_reg.kind == EMB_DATA_READ) |=> !READ_STROBE_N)
        else $error("Read strobe missing.");
    wr_strobe_a: assert property (@(posedge CORE_CLK) disable iff (rst_i) // see (R7)
        (strb && req_reg.kind == EMB_DATA_WRITE) |=> !WRITE_STROBE_N && LOW_ADDR_DATA_PORT_OE)
        else $error("Write strobe missing.");
    fetch_strobe_a: assert property (@(posedge CORE_CLK) disable iff (rst_i) // see (R3)
        (strb && req_reg.kind == EMB_CODE_READ) |=> !PROGRAM_FETCH_STROBE_N)
        else $error("Fetch strobe missing.");
    latch_pulse_a: assert property (@(posedge CORE_CLK) disable iff (rst_i) // see (R4)
        ($rose(state_reg == EMB_ADDR)) |=> ##1 ADDR_LATCH)
        else $error("Address latch not pulsed.");
    addr_phase_a: assert property (@(posedge CORE_CLK) disable iff (rst_i) // see (R5)
        (state_reg == EMB_ADDR) |=> LOW_ADDR_DATA_PORT_OUT == $past(req_reg.addr[7:0]))
        else $error("Low address not driven.");
    high_addr_a: assert property (@(posedge CORE_CLK) disable iff (rst_i) // see (R6)
        strb |=> HIGH_ADDR_PORT == $past(req_reg.addr[15:8]))
        else $error("High address wrong.");
    mc_len_a: assert property (@(posedge CORE_CLK) disable iff (rst_i) // see (R2)
        $rose(state_reg == EMB_ADDR) |-> (state_reg == EMB_ADDR) [*4] ##1 (state_reg == EMB_STRB))
        else $error("Machine cycle not four clocks.");
    sram_reset_a: assert property (@(posedge CORE_CLK) // see (R14)
        rst_i |=> !sram_en_reg)
        else $error("SRAM enable not cleared by reset.");
    wait_hold_a: assert property (@(posedge CORE_CLK) disable iff (rst_i) // see (R16)
        (state_reg == EMB_WAIT) |=> (READ_STROBE_N != WRITE_STROBE_N))
        else $error("Wait did not hold the strobe.");
endmodule : emb_bus

// File: testbench/emb_ext_mem.sv
// Purpose: External memory and wait source facing the bus.
// Assumes: The bench resolves the port 0 level from both drivers.
// Notes: Released data holds for one cycle, then toggles each cycle so stale bytes never match.
`timescale 1ns/10ps
module emb_ext_mem (
    input wire logic clk,
    input wire logic [7:0] hi,
    input wire logic [7:0] bus,
    input wire logic oe,
    input wire logic ale,
    input wire logic fetch_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] wait_len,
    output logic [7:0] drive,
    output logic wait_n
);
    logic [7:0] mem [logic [15:0]];
    logic [7:0] lo_reg = 8'h00;
    logic [7:0] cnt_reg = 8'h00;
    logic act_reg = 1'h0;
    logic hold_reg = 1'h0;
    logic [15:0] a;
    assign a = {hi, lo_reg};
    assign wait_n = (cnt_reg == 8'h00);
    initial drive = 8'h00;
    // Wait starts at the address latch so it clears the pin synchroniser before the shortest strobe ends.
    always @(posedge clk) begin
        if (ale) lo_reg <= bus;
        if (!wr_n && oe) mem[a] = bus;
        act_reg <= ale;
        if (ale && !act_reg) cnt_reg <= wait_len;
        else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
        hold_reg <= !(rd_n && fetch_n);
        if (!(rd_n && fetch_n)) drive <= mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8];
        else if (!hold_reg) drive <= ~drive;
    end
endmodule : emb_ext_mem

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the external memory bus.
// Assumes: One request at a time, dropped as soon as DONE is seen.
// Notes: Reference memories live in the bench, apart from the partner.
`timescale 1ns/10ps
module tb_top
    import emb_pkg::*;
;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic rv = 1'h0;
    emb_req_t rq = '0;
    logic [2:0] st = 3'h0;
    logic se_wr = 1'h0;
    logic se_val = 1'h0;
    logic wen = 1'h0;
    logic [7:0] wlen = 8'h00;
    logic [7:0] p_out, p_drv, hi, rdata;
    logic oe, ale, f_n, w_n, r_n, en, irst, done, wt_n, ale_d;
    logic [15:0] ad;
    logic [15:0] tbl [4] = '{16'h0000, 16'h03FF, 16'h0400, 16'hFFFF};
    int err_total = 0, comparisons = 0, rst_seen = 0, seed = 32'h4CAE517A;
    int mon [5];
    logic [7:0] ref_m [logic [15:0]];
    logic [7:0] sram_m [logic [15:0]];
    initial forever #4 clk = ~clk;
    emb_bus DUT (.CORE_CLK(clk), .RST(rst), .REQ_VALID(rv), .REQ(rq), .STRETCH(st), .SRAM_EN_WR(se_wr),
        .SRAM_EN_VAL(se_val), .WAIT_EN(wen), .P4_0_IN(wt_n), .LOW_ADDR_DATA_PORT_IN(oe ? p_out : p_drv),
        .LOW_ADDR_DATA_PORT_OUT(p_out), .LOW_ADDR_DATA_PORT_OE(oe), .HIGH_ADDR_PORT(hi), .ADDR_LATCH(ale),
        .PROGRAM_FETCH_STROBE_N(f_n), .WRITE_STROBE_N(w_n), .READ_STROBE_N(r_n),
        .ONCHIP_SRAM_ENABLE(en), .INT_RESET(irst), .DONE(done), .RDATA(rdata));
    emb_ext_mem mem_model (.clk(clk), .hi(hi), .bus(p_out), .oe(oe), .ale(ale), .fetch_n(f_n),
        .rd_n(r_n), .wr_n(w_n), .wait_len(wlen), .drive(p_drv), .wait_n(wt_n));
    always @(posedge clk) begin
        ale_d <= ale;
        if (ale && !ale_d) mon[3]++;
        if (!f_n) mon[0]++;
        if (!r_n) mon[1]++;
        if (!w_n) mon[2]++;
        if ((!r_n && oe) || (!(f_n && r_n && w_n) && hi !== rq.addr[15:8])) mon[4]++;
        if (irst === 1'h1) rst_seen++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    task automatic do_reset(input int len);
        int n;
        @(posedge clk);
        rst_seen = 0;
        rst <= 1'h1;
        repeat (len) @(posedge clk);
        rst <= 1'h0;
        n = 0;
        while ((rst_seen == 0 || irst !== 1'h0) && n < 40) begin
            @(negedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
    endtask : do_reset
    task automatic xfer(input emb_kind_t k, input logic [15:0] a, input logic [7:0] d, input int s, input int w);
        int n, base, ext, eff;
        logic [7:0] ev;
        logic intl;
        @(negedge clk);
        mon = '{default: 0};
        @(posedge clk);
        rq <= '{k, a, d};
        st <= s[2:0];
        wen <= (w > 0);
        wlen <= 8'((w < 0 ? -w : w) * 4);
        rv <= 1'h1;
        intl = en && a <= 16'h03FF && k != EMB_CODE_READ;
        ext = w > 0 ? w : 0;
        eff = intl ? 0 : 4 * (1 + (k == EMB_CODE_READ ? 0 : s));
        base = intl ? 1 : 4 + eff + 2;
        ev = intl ? sram_m[a] : (ref_m.exists(a) ? ref_m[a] : a[7:0] ^ a[15:8]);
        @(posedge clk);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (done !== 1'h1 && n < 300);
        rv = 1'h0;
        if (k != EMB_DATA_WRITE) chk(rdata, ev);
        else if (intl) sram_m[a] = d;
        else ref_m[a] = d;
        if (ext == 0) chk(n, base);
        else chk(n > base && (n - base) % 4 == 0, 1);
        if (ext == 0) chk(mon[0] + mon[1] + mon[2], eff);
        else chk(mon[0] + mon[1] + mon[2], n - 6);
        chk({mon[0] > 0, mon[1] > 0, mon[2] > 0, mon[3][7:0]},
            {k == EMB_CODE_READ && !intl, k == EMB_DATA_READ && !intl, k == EMB_DATA_WRITE && !intl, 8'(!intl)});
        chk(mon[4], 0);
    endtask : xfer
    initial begin
        #(8 * 40000);
        err_total++;
        complete_run();
    end
    initial begin
        do_reset(8);
        chk(rst_seen > 0, 1);
        chk(en, 1'h0);
        xfer(EMB_DATA_WRITE, 16'h0010, 8'hA5, 0, 0);
        xfer(EMB_DATA_READ, 16'h0010, 8'h00, 0, 0);
        for (int i = 0; i < 8; i++) begin
            ad = 16'($random(seed));
            xfer(EMB_CODE_READ, ad, 8'h00, i, 0);
            xfer(EMB_DATA_WRITE, ad, 8'($random(seed)), i, 0);
            xfer(EMB_DATA_READ, ad, 8'h00, 7 - i, 0);
        end
        @(posedge clk);
        se_val <= 1'h1;
        se_wr <= 1'h1;
        @(posedge clk);
        se_wr <= 1'h0;
        repeat (2) @(posedge clk);
        chk(en, 1'h1);
        foreach (tbl[j]) xfer(EMB_DATA_WRITE, tbl[j], 8'(8'h3C + j), j, 0);
        foreach (tbl[j]) xfer(EMB_DATA_READ, tbl[j], 8'h00, 3 - j, 0);
        foreach (tbl[j]) xfer(EMB_CODE_READ, tbl[j], 8'h00, 0, 0);
        xfer(EMB_DATA_READ, 16'h8001, 8'h00, 1, 2);
        xfer(EMB_DATA_WRITE, 16'h8001, 8'h5C, 0, 3);
        xfer(EMB_DATA_READ, 16'h8001, 8'h00, 0, -2);
        rst_seen = 0;
        @(posedge clk);
        rst <= 1'h1;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        repeat (12) @(posedge clk);
        chk(rst_seen, 0);
        chk(en, 1'h1);
        do_reset(8);
        chk(rst_seen > 0, 1);
        chk(en, 1'h0);
        xfer(EMB_DATA_READ, 16'h0010, 8'h00, 2, 0);
        complete_run();
    end
endmodule : tb_top
